/* File: hw/sfs_defines.svh */
// constants for the serial flash link: both ends and the shared package
// assumes inclusion by bare name from the package and both ends
//
// Behaviour
// - device shifts output bits on clock falls
// - device samples input bits on clock rises
// - command, address, data all enter on input line
// - deselected device floats its output line
// - deselected and idle means standby power
// - select low means active power
// - nothing accepted before first select fall
// - pause suspends transfer, select stays low
// - paused device floats output, ignores clock, data
// - pause only starts while selected
// - protect pin freezes block protect bits
// - page program takes one to 256 bytes
// - address splits into sector, page, byte
// - bulk erase and sector erase requests
// - clock idle low or high, same edges
`ifndef SFS_DEFINES_SVH
`define SFS_DEFINES_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SFS_CLK_NS 50
`define SFS_SCK_HALF_NS 400
`define SFS_HALF_CYC ((`SFS_SCK_HALF_NS + `SFS_CLK_NS - 1) / `SFS_CLK_NS)

// ----------------------------------------------------------------
// array shape and framing
// ----------------------------------------------------------------
`define SFS_SECTORS 8
`define SFS_PAGES_PER_SECTOR 256
`define SFS_PAGE_BYTES 256
`define SFS_ADDR_BITS 24
`define SFS_BIT_LAST 3'h7
`define SFS_BIT_FIRST 3'h0
`define SFS_IDX_CMD 3'h0
`define SFS_IDX_BULK 3'h1
`define SFS_IDX_DATA 3'h4
`define SFS_IDX_MAX 3'h5
`define SFS_CNT_MIN 9'h001
`define SFS_CNT_MAX 9'h100
`define SFS_BYTE_IDLE 8'hff
`define SFS_BP_RST 3'h0

// ----------------------------------------------------------------
// pin sample vector: {wp_n, hold_n, cs_n, mosi, sck}
// ----------------------------------------------------------------
`define SFS_IN_SCK 0
`define SFS_IN_MOSI 1
`define SFS_IN_CS 2
`define SFS_IN_HOLD 3
`define SFS_IN_WP 4
`define SFS_SYNC_RST 5'h18

`endif

/* File: hw/sfs_pkg.sv */
// shared types for the serial flash link
// assumes the defines header is on the include path
package sfs_pkg;
`include "sfs_defines.svh"

	typedef logic [7:0] sfs_byte_t;

	// flash address: sector, page in sector, byte in page
	typedef struct packed
	{
		logic [$clog2(`SFS_SECTORS)-1:0] sector;
		logic [$clog2(`SFS_PAGES_PER_SECTOR)-1:0] page;
		logic [$clog2(`SFS_PAGE_BYTES)-1:0] column;
	} sfs_addr_t;

	// host sequencer states
	typedef enum logic [2:0] {hs_idle, hs_lead, hs_low, hs_high, hs_gap, hs_tail} sfs_hst_t;

endpackage

/* File: hw/sfs_link_if.sv */
// link wires between host end and device end
// assumes an idle-high pull on the shared output line
`timescale 1ns/100ps
`default_nettype none

interface sfs_link_if;
	logic sck;
	logic mosi;
	logic cs_n;
	logic hold_n;
	logic wp_n;
	logic miso_o;
	logic miso_oe;
	logic miso;

	// resolved output line, pulled high when undriven
	assign miso = miso_oe ? miso_o : 1'b1;

	modport dev (input sck, input mosi, input cs_n, input hold_n, input wp_n,
		output miso_o, output miso_oe);
	modport host (output sck, output mosi, output cs_n, output hold_n, output wp_n,
		input miso);
endinterface

`default_nettype wire

/* File: hw/sfs_buf2.sv */
// small ring buffer with valid/ready on both sides
// assumes a single clock domain for filler and drain
`timescale 1ns/100ps
`default_nettype none

module sfs_buf2 #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	// advance a pointer with wrap at depth
	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction

	// handshakes and head word
	assign in_ready = (cnt_q != FULL);
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// storage, no reset needed
	always_ff @(posedge clk)
	begin
		if (push)
		begin
			mem_q[wr_q] <= in_data;
		end
	end

	// pointers and fill count
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wr_q <= bump(wr_q);
			if (pop)
				rd_q <= bump(rd_q);
			if (push && !pop)
				cnt_q <= cnt_q + (AW+1)'(1);
			else if (pop && !push)
				cnt_q <= cnt_q - (AW+1)'(1);
		end
	end
endmodule

`default_nettype wire

/* File: hw/sfs_host_end.sv */
// master end of the serial flash link: clock divider and byte sequencer
// assumes user logic on clk; read bytes drain through a two-entry buffer
`timescale 1ns/100ps
`default_nettype none
`include "sfs_defines.svh"

module sfs_host_end #(
	parameter int HALF_CYC = `SFS_HALF_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	sfs_link_if.host link,
	input wire logic cpol,
	input wire logic pause,
	input wire logic wp_protect,
	input wire logic xfer_valid,
	input wire sfs_pkg::sfs_byte_t xfer_data,
	input wire logic xfer_last,
	output logic xfer_ready,
	output logic rd_valid,
	output sfs_pkg::sfs_byte_t rd_data,
	input wire logic rd_ready,
	output logic busy
);
	import sfs_pkg::*;

	sfs_hst_t st_q;
	logic [7:0] tmr_q;
	logic [2:0] bit_q;
	sfs_byte_t tx_q;
	sfs_byte_t rx_q;
	logic last_q;
	logic cs_n_q;
	logic sck_q;
	logic hold_n_q;
	logic wp_n_q;
	logic push_q;
	logic miso_meta_q;
	logic miso_s_q;
	logic buf_rdy;
	logic run;
	logic half;
	logic take;

	// ----------------------------------------------------------------
	// pins
	// ----------------------------------------------------------------
	assign link.sck = sck_q;
	assign link.mosi = tx_q[7];
	assign link.cs_n = cs_n_q;
	assign link.hold_n = hold_n_q;
	assign link.wp_n = wp_n_q;
	assign busy = (st_q != hs_idle);

	// returning data line through two flops
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			miso_meta_q <= 1'b1;
			miso_s_q <= 1'b1;
		end
		else
		begin
			miso_meta_q <= link.miso;
			miso_s_q <= miso_meta_q;
		end
	end

	// pause only while selected; clock frozen meanwhile
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			hold_n_q <= 1'b1;
			wp_n_q <= 1'b1;
		end
		else
		begin
			hold_n_q <= ~(pause & ~cs_n_q);
			wp_n_q <= ~wp_protect;
		end
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	assign run = hold_n_q & ~pause;
	assign half = run & (tmr_q >= 8'(HALF_CYC - 1));
	// new byte only when its read-back has room, a pending push counted
	assign take = xfer_valid & buf_rdy & ~push_q &
		(((st_q == hs_idle) & half) | ((st_q == hs_gap) & run));
	assign xfer_ready = take;

	// half-period timer, restarts on every step and while paused
	// a full half after a pause lets the device drive its line again
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			tmr_q <= '0;
		else if (take || !run || (half && st_q != hs_idle && st_q != hs_gap))
			tmr_q <= '0;
		else if (run && !half)
			tmr_q <= tmr_q + 8'h1;
	end

	// clock edges, shifting, select
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_q <= hs_idle;
			bit_q <= `SFS_BIT_FIRST;
			tx_q <= `SFS_BYTE_IDLE;
			rx_q <= '0;
			last_q <= 1'b0;
			cs_n_q <= 1'b1;
			sck_q <= 1'b0;
			push_q <= 1'b0;
		end
		else
		begin
			push_q <= 1'b0;
			if (take)
			begin
				tx_q <= xfer_data;
				last_q <= xfer_last;
				cs_n_q <= 1'b0;
				bit_q <= `SFS_BIT_FIRST;
				st_q <= (st_q == hs_idle) ? hs_lead : hs_low;
				if (st_q == hs_gap)
					sck_q <= 1'b0;
			end
			else
			begin
				case (st_q)
					hs_idle:
						sck_q <= cpol;
					hs_lead:
						if (half)
						begin
							sck_q <= 1'b0;
							st_q <= hs_low;
						end
					hs_low:
						if (half)
						begin
							sck_q <= 1'b1;
							rx_q <= {rx_q[6:0], miso_s_q};
							st_q <= hs_high;
						end
					hs_high:
						if (half)
						begin
							if (bit_q != `SFS_BIT_LAST)
							begin
								sck_q <= 1'b0;
								bit_q <= bit_q + 3'h1;
								tx_q <= {tx_q[6:0], 1'b1};
								st_q <= hs_low;
							end
							else
							begin
								push_q <= 1'b1;
								st_q <= last_q ? hs_tail : hs_gap;
								if (last_q)
									sck_q <= 1'b0;
							end
						end
					hs_gap:
						st_q <= hs_gap;
					hs_tail:
						if (half)
						begin
							cs_n_q <= 1'b1;
							sck_q <= cpol;
							st_q <= hs_idle;
						end
					default:
						st_q <= hs_idle;
				endcase
			end
		end
	end

	// read-back bytes toward user logic
	sfs_buf2 #(.WIDTH(8), .DEPTH(2)) u_rd_buf (
		.clk(clk),
		.nrst(nrst),
		.in_valid(push_q),
		.in_data(rx_q),
		.in_ready(buf_rdy),
		.out_valid(rd_valid),
		.out_data(rd_data),
		.out_ready(rd_ready)
	);
endmodule

`default_nettype wire

/* File: hw/sfs_dev_end.sv */
// device end of the serial flash link: pin sampling, byte framing,
// command decode into program and erase requests, power and protect state
// assumes all link pins come from outside clk and are oversampled
`timescale 1ns/100ps
`default_nettype none
`include "sfs_defines.svh"

module sfs_dev_end #(
	parameter logic [7:0] PAGE_PROGRAM_CMD = 8'h01,
	parameter logic [7:0] SECTOR_ERASE_CMD = 8'h02,
	parameter logic [7:0] WHOLE_ARRAY_ERASE_CMD = 8'h03
) (
	input wire logic clk,
	input wire logic nrst,
	sfs_link_if.dev link,
	output logic rx_valid,
	output sfs_pkg::sfs_byte_t rx_data,
	output logic rx_is_data,
	input wire logic tx_valid,
	input wire sfs_pkg::sfs_byte_t tx_data,
	output logic tx_ready,
	input wire logic busy,
	output logic active,
	output logic standby,
	output logic prog_req,
	output sfs_pkg::sfs_addr_t prog_addr,
	output logic [8:0] prog_count,
	output logic sect_erase_req,
	output sfs_pkg::sfs_addr_t erase_addr,
	output logic bulk_erase_req,
	input wire logic bp_wr_valid,
	input wire logic [2:0] bp_wr_data,
	output logic [2:0] block_protect,
	output logic bp_locked
);
	import sfs_pkg::*;

	logic [4:0] meta_q;
	logic [4:0] sync_q;
	logic sck_prev_q;
	logic cs_prev_q;
	logic armed_q;
	logic hold_q;
	logic started_q;
	logic [2:0] bit_cnt_q;
	logic [2:0] idx_q;
	sfs_byte_t shreg_q;
	sfs_byte_t cmd_q;
	logic [`SFS_ADDR_BITS-1:0] addr_q;
	logic [8:0] cnt_q;
	sfs_byte_t tx_sh_q;
	logic miso_q;
	logic oe_q;
	logic selected;
	logic live;
	logic cs_fall;
	logic cs_rise;
	logic sck_rise;
	logic sck_fall;
	logic load_evt;
	logic shift_evt;
	logic whole;
	sfs_byte_t in_byte;

	// cut a wide address into sector, page, byte
	function automatic sfs_addr_t split_addr(input logic [`SFS_ADDR_BITS-1:0] a);
		split_addr = a[$bits(sfs_addr_t)-1:0];
	endfunction

	// ----------------------------------------------------------------
	// pin sampling and edge finding
	// ----------------------------------------------------------------

	// two flops on every pin before any use
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			meta_q <= `SFS_SYNC_RST;
			sync_q <= `SFS_SYNC_RST;
		end
		else
		begin
			meta_q <= {link.wp_n, link.hold_n, link.cs_n, link.mosi, link.sck};
			sync_q <= meta_q;
		end
	end

	// previous levels for edge detection
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sck_prev_q <= 1'b0;
			cs_prev_q <= 1'b0;
		end
		else
		begin
			sck_prev_q <= sync_q[`SFS_IN_SCK];
			cs_prev_q <= sync_q[`SFS_IN_CS];
		end
	end

	assign selected = ~sync_q[`SFS_IN_CS];
	assign cs_fall = selected & cs_prev_q;
	assign cs_rise = ~selected & ~cs_prev_q;
	// clock edges count only when selected, armed and not paused
	assign live = selected & armed_q & ~hold_q;
	assign sck_rise = live & sync_q[`SFS_IN_SCK] & ~sck_prev_q;
	assign sck_fall = live & ~sync_q[`SFS_IN_SCK] & sck_prev_q;
	assign in_byte = {shreg_q[6:0], sync_q[`SFS_IN_MOSI]};
	assign whole = (bit_cnt_q == `SFS_BIT_FIRST);

	// armed by the first select fall after reset
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			armed_q <= 1'b0;
		else if (cs_fall)
			armed_q <= 1'b1;
	end

	// pause follows the pin only while selected
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			hold_q <= 1'b0;
		else if (!selected)
			hold_q <= 1'b0;
		else
			hold_q <= ~sync_q[`SFS_IN_HOLD];
	end

	// ----------------------------------------------------------------
	// receive framing
	// ----------------------------------------------------------------

	// bit and byte position within the frame
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			bit_cnt_q <= `SFS_BIT_FIRST;
			idx_q <= `SFS_IDX_CMD;
			started_q <= 1'b0;
			shreg_q <= '0;
		end
		else if (!selected || cs_fall)
		begin
			bit_cnt_q <= `SFS_BIT_FIRST;
			idx_q <= `SFS_IDX_CMD;
			started_q <= 1'b0;
		end
		else if (sck_rise)
		begin
			shreg_q <= in_byte;
			bit_cnt_q <= bit_cnt_q + 3'h1;
			started_q <= 1'b1;
			if (bit_cnt_q == `SFS_BIT_LAST && idx_q != `SFS_IDX_MAX)
				idx_q <= idx_q + 3'h1;
		end
	end

	// command, address and data byte capture
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cmd_q <= '0;
			addr_q <= '0;
			cnt_q <= '0;
			rx_valid <= 1'b0;
			rx_data <= '0;
			rx_is_data <= 1'b0;
		end
		else
		begin
			rx_valid <= 1'b0;
			if (cs_fall)
				cnt_q <= '0;
			if (sck_rise && bit_cnt_q == `SFS_BIT_LAST)
			begin
				rx_valid <= 1'b1;
				rx_data <= in_byte;
				rx_is_data <= (idx_q >= `SFS_IDX_DATA);
				if (idx_q == `SFS_IDX_CMD)
					cmd_q <= in_byte;
				else if (idx_q < `SFS_IDX_DATA)
					addr_q <= {addr_q[`SFS_ADDR_BITS-9:0], in_byte};
				else if (cmd_q == PAGE_PROGRAM_CMD && cnt_q != `SFS_CNT_MAX)
					cnt_q <= cnt_q + 9'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// requests at deselect, whole bytes only
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			prog_req <= 1'b0;
			prog_addr <= '0;
			prog_count <= '0;
			sect_erase_req <= 1'b0;
			erase_addr <= '0;
			bulk_erase_req <= 1'b0;
		end
		else
		begin
			prog_req <= 1'b0;
			sect_erase_req <= 1'b0;
			bulk_erase_req <= 1'b0;
			if (cs_rise && armed_q && whole)
			begin
				if (cmd_q == PAGE_PROGRAM_CMD && idx_q >= `SFS_IDX_DATA &&
					cnt_q >= `SFS_CNT_MIN)
				begin
					prog_req <= 1'b1;
					prog_addr <= split_addr(addr_q);
					prog_count <= cnt_q;
				end
				if (cmd_q == SECTOR_ERASE_CMD && idx_q == `SFS_IDX_DATA)
				begin
					sect_erase_req <= 1'b1;
					erase_addr <= split_addr(addr_q);
				end
				if (cmd_q == WHOLE_ARRAY_ERASE_CMD && idx_q == `SFS_IDX_BULK)
					bulk_erase_req <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// transmit path
	// ----------------------------------------------------------------

	// load at select and at each byte boundary fall
	assign load_evt = cs_fall | (sck_fall & started_q & whole);
	// the lone fall before the first rise is skipped
	assign shift_evt = sck_fall & started_q & ~whole;
	assign tx_ready = load_evt;

	// output shifter, msb first
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			tx_sh_q <= `SFS_BYTE_IDLE;
		else if (load_evt)
			tx_sh_q <= tx_valid ? tx_data : `SFS_BYTE_IDLE;
		else if (shift_evt)
			tx_sh_q <= {tx_sh_q[6:0], 1'b1};
	end

	// output drive, floated when deselected or paused
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			miso_q <= 1'b1;
			oe_q <= 1'b0;
		end
		else
		begin
			miso_q <= load_evt ? (tx_valid ? tx_data[7] : 1'b1) :
				(shift_evt ? tx_sh_q[6] : tx_sh_q[7]);
			oe_q <= selected & armed_q & ~hold_q;
		end
	end

	assign link.miso_o = miso_q;
	assign link.miso_oe = oe_q;

	// ----------------------------------------------------------------
	// power state and protect bits
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			active <= 1'b0;
			standby <= 1'b1;
			bp_locked <= 1'b0;
			block_protect <= `SFS_BP_RST;
		end
		else
		begin
			active <= selected | busy;
			standby <= ~selected & ~busy;
			bp_locked <= ~sync_q[`SFS_IN_WP];
			if (bp_wr_valid && sync_q[`SFS_IN_WP])
				block_protect <= bp_wr_data;
		end
	end
endmodule

`default_nettype wire

/* File: testbench/sfs_link_chk.sv */
// link-wire assertions between host end and device end
// assumes clk oversamples the link and nrst is async, active low
`timescale 1ns/100ps
`default_nettype none

module sfs_link_chk (
	input wire logic clk,
	input wire logic nrst,
	input wire logic sck,
	input wire logic mosi,
	input wire logic cs_n,
	input wire logic hold_n,
	input wire logic wp_n,
	input wire logic miso_o,
	input wire logic miso_oe,
	input wire logic miso
);
	// --------------------------------
	// clock rises within a frame
	// --------------------------------
	logic [11:0] rises_q;
	logic sck_q;

	// count rises while selected
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rises_q <= 12'h000;
			sck_q <= 1'b0;
		end
		else
		begin
			sck_q <= sck;
			if (cs_n)
				rises_q <= 12'h000;
			else if (sck && !sck_q)
				rises_q <= rises_q + 12'h001;
		end
	end

	// --------------------------------
	// properties
	// --------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	property p_float_desel;
		cs_n [*6] |-> !miso_oe && miso;
	endproperty
	a_float_desel: assert property (p_float_desel) else $error("output driven when idle");

	property p_float_hold;
		(!hold_n && !cs_n) [*6] |-> !miso_oe;
	endproperty
	a_float_hold: assert property (p_float_hold) else $error("output driven in pause");

	property p_out_stable;
		$rose(sck) && miso_oe |=> $stable(miso_o) [*6];
	endproperty
	a_out_stable: assert property (p_out_stable) else $error("output moved in high half");

	property p_in_stable;
		$rose(sck) && !cs_n |-> $stable(mosi) [*7];
	endproperty
	a_in_stable: assert property (p_in_stable) else $error("input moved near rise");

	property p_lead;
		$fell(cs_n) |-> $stable(sck) [*6];
	endproperty
	a_lead: assert property (p_lead) else $error("clock moved at select");

	property p_whole;
		$rose(cs_n) |-> rises_q[2:0] == 3'h0;
	endproperty
	a_whole: assert property (p_whole) else $error("partial byte in frame");

	property p_hold_sel;
		$fell(hold_n) |-> !cs_n;
	endproperty
	a_hold_sel: assert property (p_hold_sel) else $error("pause while deselected");

	property p_hold_freeze;
		(!hold_n) [*2] |-> $stable(sck) && $stable(cs_n);
	endproperty
	a_hold_freeze: assert property (p_hold_freeze) else $error("link moved in pause");
endmodule

`default_nettype wire

/* File: testbench/testbench.sv */
// bench: host end and device end on one link, a bare device end on another
// assumes the package, interface and design ends are compiled first
`timescale 1ns/100ps
`default_nettype none

module testbench;
	import sfs_pkg::*;

	// --------------------------------
	// signals
	// --------------------------------
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic cpol = 1'b0;
	logic pause = 1'b0;
	logic wpp = 1'b0;
	logic xv = 1'b0;
	logic xl = 1'b0;
	logic rr = 1'b0;
	logic tv = 1'b0;
	logic dbusy = 1'b0;
	logic bwv = 1'b0;
	logic rd_en = 1'b1;
	logic p_en = 1'b0;
	logic s_q = 1'b0;
	logic [2:0] bwd = 3'h0;
	sfs_byte_t xd = 8'h00;
	sfs_byte_t td = 8'h00;
	logic xr, rv, hbusy, rxv, rxi, tr, act, stb, prq, seq, beq, beq2, bpl;
	sfs_byte_t rd, rxd, wsh;
	sfs_addr_t pra, era, pa, ea;
	logic [8:0] prc, pc;
	logic [2:0] bp;
	sfs_byte_t fb[$], rxq[$], rdq[$], txq[$], wq[$];
	logic isq[$];
	int failures = 0;
	int cmp_count = 0;
	int seed = 10;
	int np, ns, nb, wn;
	int nb2 = 0;

	sfs_link_if lk();
	sfs_link_if lk2();
	sfs_host_end i_sfs_host_end (.clk(clk), .nrst(nrst), .link(lk.host), .cpol(cpol),
		.pause(pause), .wp_protect(wpp), .xfer_valid(xv), .xfer_data(xd), .xfer_last(xl),
		.xfer_ready(xr), .rd_valid(rv), .rd_data(rd), .rd_ready(rr), .busy(hbusy));
	sfs_dev_end i_sfs_dev_end (.clk(clk), .nrst(nrst), .link(lk.dev), .rx_valid(rxv),
		.rx_data(rxd), .rx_is_data(rxi), .tx_valid(tv), .tx_data(td), .tx_ready(tr),
		.busy(dbusy), .active(act), .standby(stb), .prog_req(prq), .prog_addr(pra),
		.prog_count(prc), .sect_erase_req(seq), .erase_addr(era), .bulk_erase_req(beq),
		.bp_wr_valid(bwv), .bp_wr_data(bwd), .block_protect(bp), .bp_locked(bpl));
	sfs_dev_end i_sfs_dev_end_b (.clk(clk), .nrst(nrst), .link(lk2.dev), .rx_valid(),
		.rx_data(), .rx_is_data(), .tx_valid(tv), .tx_data(td), .tx_ready(), .busy(dbusy),
		.active(), .standby(), .prog_req(), .prog_addr(), .prog_count(), .sect_erase_req(),
		.erase_addr(), .bulk_erase_req(beq2), .bp_wr_valid(bwv), .bp_wr_data(bwd),
		.block_protect(), .bp_locked());
	sfs_link_chk i_sfs_link_chk (.clk(clk), .nrst(nrst), .sck(lk.sck), .mosi(lk.mosi),
		.cs_n(lk.cs_n), .hold_n(lk.hold_n), .wp_n(lk.wp_n), .miso_o(lk.miso_o),
		.miso_oe(lk.miso_oe), .miso(lk.miso));

	// 50 ns clock
	always #25 clk = ~clk;

	// random user stimulus just after each rise
	always @(posedge clk)
	begin
		#1;
		tv = 1'($random(seed));
		td = 8'($random(seed));
		rr = rd_en & 1'($random(seed));
		pause = p_en & (pause ^ ($random(seed) % 32 == 0));
	end

	// collect bytes, requests and wire bits
	always @(posedge clk)
	begin
		if (rxv)
		begin
			rxq.push_back(rxd);
			isq.push_back(rxi);
		end
		if (rv && rr)
			rdq.push_back(rd);
		if (tr)
			txq.push_back(tv ? td : 8'hff);
		if (prq)
		begin
			np++;
			pa = pra;
			pc = prc;
		end
		if (seq)
		begin
			ns++;
			ea = era;
		end
		nb += beq;
		nb2 += beq2;
		if (lk.sck && !s_q && !lk.cs_n && lk.hold_n)
		begin
			wsh = {wsh[6:0], lk.mosi};
			wn++;
			if (wn % 8 == 0)
				wq.push_back(wsh);
		end
		s_q = lk.sck;
	end

	// --------------------------------
	// tasks and expectations
	// --------------------------------
	task automatic chk(input logic c, input string m);
		cmp_count++;
		if (!c)
		begin
			failures++;
			$display("Error %0t %s", $time, m);
		end
	endtask

	task automatic results;
		$display("checks %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// request kind: {program, sector erase, bulk erase}
	function automatic logic [2:0] kind(input sfs_byte_t c, input int n);
		kind = {c == 8'h01 && n > 4, c == 8'h02 && n == 4, c == 8'h03 && n == 1};
	endfunction

	// low 19 address bits: sector, page, column
	function automatic sfs_addr_t addr_exp();
		addr_exp = {fb[1][2:0], fb[2], fb[3]};
	endfunction

	// bare device: one byte pin by pin, msb first
	task automatic bb(input sfs_byte_t b);
		for (int i = 7; i >= 0; i--)
		begin
			lk2.mosi = b[i];
			cyc(8);
			lk2.sck = 1'b1;
			cyc(8);
			lk2.sck = 1'b0;
		end
	endtask

	// protect bits write, then compare
	task automatic bpw(input logic [2:0] v, input logic [2:0] e);
		bwd = v;
		bwv = 1'b1;
		cyc(1);
		bwv = 1'b0;
		cyc(4);
		chk(bp === e && bpl === wpp, "protect bits");
	endtask

	// send fb as one frame, then compare everything
	task automatic frame;
		int t;
		logic [2:0] k;
		rxq.delete();
		isq.delete();
		rdq.delete();
		txq.delete();
		wq.delete();
		wn = 0;
		np = 0;
		ns = 0;
		nb = 0;
		foreach (fb[i])
		begin
			xv = 1'b1;
			xd = fb[i];
			xl = (i == fb.size() - 1);
			@(negedge clk);
			for (t = 0; !xr && t < 9000; t++)
				@(negedge clk);
			cyc(1);
		end
		xv = 1'b0;
		for (t = 0; (hbusy || rdq.size() < fb.size()) && t < 9000; t++)
			cyc(1);
		cyc(12);
		k = kind(fb[0], fb.size());
		chk(rxq.size() == fb.size() && wq.size() == fb.size(), "byte count");
		foreach (fb[i])
		begin
			chk(rxq[i] === fb[i] && isq[i] === (i >= 4), "device byte");
			chk(wq[i] === fb[i], "wire bit order");
			chk(rdq[i] === txq[i], "read-back byte");
		end
		chk(np == k[2] && ns == k[1] && nb == k[0], "request kind");
		if (k[2])
			chk(pa === addr_exp() && pc === 9'(fb.size() - 4), "program");
		if (k[1])
			chk(ea === addr_exp(), "erase address");
		chk(lk.cs_n === 1'b1 && lk.miso === 1'b1 && lk.sck === cpol, "idle wire");
	endtask

	// --------------------------------
	// sequence and watchdog
	// --------------------------------
	initial
	begin
		lk2.sck = 1'b0;
		lk2.mosi = 1'b1;
		lk2.cs_n = 1'b0;
		lk2.hold_n = 1'b1;
		lk2.wp_n = 1'b1;
		cyc(5);
		nrst = 1'b1;
		cyc(20);
		bb(8'h03);
		lk2.cs_n = 1'b1;
		lk2.mosi = 1'b0;
		cyc(10);
		chk(nb2 == 0, "command before select fall");
		lk2.cs_n = 1'b0;
		cyc(8);
		bb(8'h03);
		lk2.cs_n = 1'b1;
		cyc(10);
		chk(nb2 == 1, "command after select fall");
		bpw(3'h5, 3'h5);
		wpp = 1'b1;
		cyc(8);
		bpw(3'h2, 3'h5);
		wpp = 1'b0;
		cyc(8);
		fb = {8'h03};
		frame();
		dbusy = 1'b1;
		fb = {8'h02, 8'hfd, 8'h5a, 8'hc3};
		frame();
		chk(stb === 1'b0, "standby while busy");
		dbusy = 1'b0;
		cyc(8);
		chk(stb === 1'b1 && act === 1'b0, "standby when idle");
		fb = {8'h01, 8'h00, 8'hff, 8'hff, 8'h81};
		frame();
		rd_en = 1'b0;
		fb = {8'h04, 8'ha5, 8'h3c};
		fork
			frame();
			begin
				cyc(700);
				chk(rxq.size() == 2 && xr === 1'b0 && act === 1'b1, "full buffer");
				rd_en = 1'b1;
			end
		join
		fb = {8'h01, 8'h07, 8'h12, 8'h00};
		repeat (256) fb.push_back(8'($random(seed)));
		frame();
		p_en = 1'b1;
		for (int k = 0; k < 8; k++)
		begin
			cpol = k[0];
			cyc(4);
			fb = {8'(1 + k % 4)};
			repeat ({$random(seed)} % 6) fb.push_back(8'($random(seed)));
			frame();
		end
		results();
	end

	initial
	begin
		repeat (95000) @(posedge clk);
		failures++;
		results();
	end
endmodule

`default_nettype wire
